// file: verilog/cbu_pkg.sv
/*
  Shared types and constants of the compare, skip and branch unit.
  Assumes an 8-bit core whose decoder hands over operand values already
  read from the working registers and the low I/O registers.
*/
package cbu_pkg;
  // Program counter width in words
  localparam int PC_W = 11;
  // Status register bit positions
  localparam int SB_C = 0;
  localparam int SB_Z = 1;
  localparam int SB_N = 2;
  localparam int SB_V = 3;
  localparam int SB_S = 4;
  localparam int SB_H = 5;
  localparam int SB_T = 6;
  localparam int SB_I = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Register port word indices
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_TGT_LO = 2'h1;
  localparam logic [1:0] REG_TGT_HI = 2'h2;
  localparam logic [1:0] REG_TAKEN = 2'h3;
  // Program counter steps and cycle counts
  localparam logic [PC_W-1:0] SKIP_SHORT = 11'h002;
  localparam logic [PC_W-1:0] SKIP_LONG = 11'h003;
  localparam logic [PC_W-1:0] BR_BIAS = 11'h001;
  localparam logic [1:0] CYC_PLAIN = 2'h1;
  localparam logic [1:0] CYC_TAKEN = 2'h2;
  localparam logic [1:0] CYC_LONG = 2'h3;

  typedef enum logic [4:0] {
    OP_COMPARE_REGS, OP_COMPARE_REGS_WITH_BORROW, OP_COMPARE_IMMEDIATE,
    OP_COMPARE_THEN_SKIP_ON_EQUAL, OP_SKIP_IF_REG_BIT_LOW, OP_SKIP_IF_REG_BIT_HIGH,
    OP_SKIP_IF_IO_BIT_LOW, OP_SKIP_IF_IO_BIT_HIGH,
    OP_BRANCH_ON_STATUS_BIT_HIGH, OP_BRANCH_ON_STATUS_BIT_LOW,
    OP_BRANCH_ON_EQUAL, OP_BRANCH_ON_UNEQUAL, OP_BRANCH_ON_CARRY_HIGH,
    OP_BRANCH_ON_CARRY_LOW, OP_BRANCH_ON_UNSIGNED_GE, OP_BRANCH_ON_UNSIGNED_LT,
    OP_BRANCH_ON_NEGATIVE, OP_BRANCH_ON_POSITIVE, OP_BRANCH_ON_SIGNED_GE,
    OP_BRANCH_ON_SIGNED_LT, OP_BRANCH_ON_NIBBLE_CARRY_HIGH,
    OP_BRANCH_ON_NIBBLE_CARRY_LOW, OP_BRANCH_ON_SPARE_BIT_HIGH,
    OP_BRANCH_ON_SPARE_BIT_LOW, OP_BRANCH_ON_WRAP_HIGH, OP_BRANCH_ON_WRAP_LOW,
    OP_BRANCH_ON_IRQ_ON, OP_BRANCH_ON_IRQ_OFF
  } cbu_op_t;

  typedef enum logic {CBU_IDLE, CBU_STALL} cbu_state_t;

  typedef struct packed {
    cbu_op_t op;
    logic [7:0] opa;
    logic [7:0] opb;
    logic [2:0] bit_sel;
    logic [7:0] io_val;
    logic [6:0] offset;
    logic [PC_W-1:0] pc;
    logic next_two_word;
  } cbu_req_t;

  typedef struct packed {
    logic done;
    logic pc_load;
    logic flush;
    logic [PC_W-1:0] pc_target;
  } cbu_res_t;

  typedef struct packed {
    cbu_state_t st;
    logic [1:0] stall;
    logic [7:0] status;
    cbu_res_t res;
    logic [7:0] rdata;
    logic [7:0] taken_cnt;
  } cbu_regs_t;
endpackage

// file: verilog/cbu_compare_skip_branch.sv
/*
  Compare, conditional skip and relative branch execution unit.
  Assumes the decoder drives one request at a time on the core clock,
  with operand values, the skip length and the instruction's own address.
*/
// Design decisions made here: the address map and the address-and-strobe port.
// Notes on behaviour
// - Register compare subtracts, keeps no result, sets Z N V C H, one cycle.
// - Compare with borrow also subtracts carry, same five flags, one cycle.
// - Immediate compare subtracts a constant, same five flags, one cycle.
// - Compare-and-skip skips when equal, no flags, one to three cycles.
// - Register bit skips test a working register bit low or high.
// - I/O bit skips test a bit of an I/O register low or high.
// - Status bit branches jump to pc plus offset plus one when matched.
// - Equality branches follow the zero flag, one or two cycles.
// - Carry branches follow the carry flag, flags untouched.
// - Unsigned ge equals carry low, unsigned lt equals carry high.
// - Sign branches follow the negative flag.
// - Signed branches test negative xor overflow.
// - Nibble carry branches follow the half carry flag.
// - Spare bit branches follow the copy flag.
// - Wrap branches follow the overflow flag.
// - Interrupt branches follow the global enable flag.
`timescale 1ns/100ps
module cbu_compare_skip_branch
  import cbu_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Instruction request
  input wire logic req_valid,
  input wire cbu_req_t req,
  output logic req_ready,
  // Result towards fetch
  output cbu_res_t res_o,
  output logic [7:0] status_o,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);

  cbu_regs_t q;
  cbu_regs_t d;
  logic accept;
  logic is_cmp;
  logic cin;
  logic [8:0] diff;
  logic [7:0] r;
  logic hit;
  logic is_skip;
  logic is_br;
  logic [PC_W-1:0] br_tgt;
  logic [PC_W-1:0] skip_tgt;
  logic [1:0] cycles;

  // Handshake is combinational; a stall holds new requests off
  assign accept = req_valid && req_ready;
  assign req_ready = (q.st == CBU_IDLE);
  assign res_o = q.res;
  assign status_o = q.status;
  assign reg_rdata = q.rdata;

  // Subtractor shared by the three compares
  assign is_cmp = (req.op == OP_COMPARE_REGS) || (req.op == OP_COMPARE_REGS_WITH_BORROW)
    || (req.op == OP_COMPARE_IMMEDIATE);
  assign cin = (req.op == OP_COMPARE_REGS_WITH_BORROW) ? q.status[SB_C] : 1'b0;
  assign diff = {1'b0, req.opa} - {1'b0, req.opb} - {8'h00, cin};
  assign r = diff[7:0];

  // Condition of the skips and branches
  always_comb begin
    hit = 1'b0;
    is_skip = 1'b0;
    is_br = 1'b1;
    unique case (req.op)
      OP_COMPARE_REGS, OP_COMPARE_REGS_WITH_BORROW, OP_COMPARE_IMMEDIATE: begin
        is_br = 1'b0;
      end
      OP_COMPARE_THEN_SKIP_ON_EQUAL: begin
        is_br = 1'b0;
        is_skip = 1'b1;
        hit = (req.opa == req.opb);
      end
      OP_SKIP_IF_REG_BIT_LOW: begin
        is_br = 1'b0;
        is_skip = 1'b1;
        hit = ~req.opa[req.bit_sel];
      end
      OP_SKIP_IF_REG_BIT_HIGH: begin
        is_br = 1'b0;
        is_skip = 1'b1;
        hit = req.opa[req.bit_sel];
      end
      OP_SKIP_IF_IO_BIT_LOW: begin
        is_br = 1'b0;
        is_skip = 1'b1;
        hit = ~req.io_val[req.bit_sel];
      end
      OP_SKIP_IF_IO_BIT_HIGH: begin
        is_br = 1'b0;
        is_skip = 1'b1;
        hit = req.io_val[req.bit_sel];
      end
      OP_BRANCH_ON_STATUS_BIT_HIGH: hit = q.status[req.bit_sel];
      OP_BRANCH_ON_STATUS_BIT_LOW: hit = ~q.status[req.bit_sel];
      OP_BRANCH_ON_EQUAL: hit = q.status[SB_Z];
      OP_BRANCH_ON_UNEQUAL: hit = ~q.status[SB_Z];
      // carry flag; unsigned aliases share it
      OP_BRANCH_ON_CARRY_HIGH, OP_BRANCH_ON_UNSIGNED_LT: hit = q.status[SB_C];
      OP_BRANCH_ON_CARRY_LOW, OP_BRANCH_ON_UNSIGNED_GE: hit = ~q.status[SB_C];
      OP_BRANCH_ON_NEGATIVE: hit = q.status[SB_N];
      OP_BRANCH_ON_POSITIVE: hit = ~q.status[SB_N];
      // sign xor wrap, not the stored sign bit
      OP_BRANCH_ON_SIGNED_GE: hit = ~(q.status[SB_N] ^ q.status[SB_V]);
      OP_BRANCH_ON_SIGNED_LT: hit = q.status[SB_N] ^ q.status[SB_V];
      OP_BRANCH_ON_NIBBLE_CARRY_HIGH: hit = q.status[SB_H];
      OP_BRANCH_ON_NIBBLE_CARRY_LOW: hit = ~q.status[SB_H];
      OP_BRANCH_ON_SPARE_BIT_HIGH: hit = q.status[SB_T];
      OP_BRANCH_ON_SPARE_BIT_LOW: hit = ~q.status[SB_T];
      OP_BRANCH_ON_WRAP_HIGH: hit = q.status[SB_V];
      OP_BRANCH_ON_WRAP_LOW: hit = ~q.status[SB_V];
      OP_BRANCH_ON_IRQ_ON: hit = q.status[SB_I];
      OP_BRANCH_ON_IRQ_OFF: hit = ~q.status[SB_I];
      default: is_br = 1'b0;
    endcase
  end

  assign br_tgt = req.pc + {{(PC_W-7){req.offset[6]}}, req.offset} + BR_BIAS;
  // two or three words depending on the skipped length
  assign skip_tgt = req.pc + (req.next_two_word ? SKIP_LONG : SKIP_SHORT);

  // Cycle count of the accepted instruction
  always_comb begin
    cycles = CYC_PLAIN;
    if (hit && is_br) begin
      cycles = CYC_TAKEN;
    end else if (hit && is_skip) begin
      // longer skip costs one more cycle
      cycles = req.next_two_word ? CYC_LONG : CYC_TAKEN;
    end
  end

  // Next state of the whole unit
  always_comb begin
    d = q;
    d.res.done = 1'b0;
    d.res.pc_load = 1'b0;
    d.res.flush = 1'b0;
    d.rdata = 8'h00;
    // Software write to status; a compare in the same cycle wins below for Z N V C H only
    if (reg_wr && reg_addr == REG_STATUS) begin
      d.status = reg_wdata;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        REG_STATUS: d.rdata = q.status;
        REG_TGT_LO: d.rdata = q.res.pc_target[7:0];
        REG_TGT_HI: d.rdata = {5'h00, q.res.pc_target[PC_W-1:8]};
        REG_TAKEN: d.rdata = q.taken_cnt;
      endcase
    end
    unique case (q.st)
      CBU_IDLE: begin
        if (accept) begin
          d.res.done = 1'b1;
          if (is_cmp) begin
            d.status[SB_N] = r[7];
            d.status[SB_C] = diff[8];
            d.status[SB_V] = (req.opa[7] & ~req.opb[7] & ~r[7])
              | (~req.opa[7] & req.opb[7] & r[7]);
            d.status[SB_H] = (~req.opa[3] & req.opb[3]) | (req.opb[3] & r[3])
              | (r[3] & ~req.opa[3]);
            // borrow compare chains zero so multi-byte compares work
            if (req.op == OP_COMPARE_REGS_WITH_BORROW) begin
              d.status[SB_Z] = (r == 8'h00) & q.status[SB_Z];
            end else begin
              // plain and immediate compares set zero directly
              d.status[SB_Z] = (r == 8'h00);
            end
          end
          // redirect fetch and drop the prefetched word
          if (hit) begin
            d.res.pc_load = 1'b1;
            d.res.flush = 1'b1;
            d.res.pc_target = is_br ? br_tgt : skip_tgt;
            d.taken_cnt = q.taken_cnt + 8'h01;
          end
          if (cycles != CYC_PLAIN) begin
            d.st = CBU_STALL;
            d.stall = cycles - CYC_PLAIN;
          end
        end
      end
      CBU_STALL: begin
        // Hold the core off while fetch refills
        d.stall = q.stall - 2'h1;
        if (q.stall == 2'h1) begin
          d.st = CBU_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q <= '{st: CBU_IDLE, stall: 2'h0, status: STATUS_RESET, res: '0, rdata: 8'h00,
        taken_cnt: 8'h00};
    end else begin
      q <= d;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_take(cbu_op_t o);
    accept && req.op == o;
  endsequence

  // Refill after a taken branch or short skip: exactly one cycle held off
  sequence s_refill_short;
    !req_ready ##1 req_ready && !res_o.done;
  endsequence

  chk_cmp_zero_flag: assert property (
    s_take(OP_COMPARE_REGS) |=> status_o[SB_Z] == ($past(req.opa) == $past(req.opb))
      && !res_o.pc_load && req_ready)
    else $error("compare zero flag or timing wrong");

  chk_borrow_carry: assert property (
    s_take(OP_COMPARE_REGS_WITH_BORROW) |=> status_o[SB_C] ==
      ({1'b0, $past(req.opa)} < {1'b0, $past(req.opb)} + {8'h00, $past(q.status[SB_C])}))
    else $error("borrow compare carry wrong");

  // Sign comes from the operands, not from the shared subtractor
  chk_imm_sign: assert property (
    s_take(OP_COMPARE_IMMEDIATE) |=> status_o[SB_N] ==
      ((($past(req.opa) - $past(req.opb)) & 8'h80) != 8'h00) && req_ready)
    else $error("immediate compare sign wrong");

  chk_equal_skip: assert property (
    s_take(OP_COMPARE_THEN_SKIP_ON_EQUAL) ##0 (req.opa == req.opb && !req.next_two_word)
      |=> res_o.pc_load && res_o.pc_target == $past(req.pc) + SKIP_SHORT
      && $stable(status_o))
    else $error("equal skip wrong");

  chk_short_skip_time: assert property (
    s_take(OP_COMPARE_THEN_SKIP_ON_EQUAL) ##0 (req.opa == req.opb && !req.next_two_word)
      |=> s_refill_short)
    else $error("short skip stall wrong");

  chk_reg_bit_skip: assert property (
    s_take(OP_SKIP_IF_REG_BIT_LOW) |=> res_o.pc_load == !$past(req.opa[req.bit_sel]))
    else $error("register bit skip wrong");

  chk_reg_bit_set: assert property (
    s_take(OP_SKIP_IF_REG_BIT_HIGH) |=> res_o.pc_load == $past(req.opa[req.bit_sel])
      && $stable(status_o))
    else $error("register bit set skip wrong");

  chk_io_bit_skip: assert property (
    s_take(OP_SKIP_IF_IO_BIT_HIGH) |=> res_o.pc_load == $past(req.io_val[req.bit_sel]))
    else $error("io bit skip wrong");

  chk_io_bit_clear: assert property (
    s_take(OP_SKIP_IF_IO_BIT_LOW) |=> res_o.pc_load == !$past(req.io_val[req.bit_sel])
      && $stable(status_o))
    else $error("io bit clear skip wrong");

  chk_status_branch: assert property (
    s_take(OP_BRANCH_ON_STATUS_BIT_HIGH) |=> res_o.pc_load == $past(q.status[req.bit_sel])
      && $stable(status_o))
    else $error("status bit branch wrong");

  chk_equal_branch: assert property (
    s_take(OP_BRANCH_ON_UNEQUAL) ##0 !status_o[SB_Z] |=> res_o.pc_load ##0 s_refill_short)
    else $error("unequal branch timing wrong");

  chk_equal_untaken: assert property (
    s_take(OP_BRANCH_ON_EQUAL) ##0 !status_o[SB_Z] |=> res_o.done && !res_o.pc_load
      && req_ready)
    else $error("untaken equal branch wrong");

  chk_carry_branch: assert property (
    s_take(OP_BRANCH_ON_CARRY_HIGH) |=> res_o.pc_load == $past(q.status[SB_C]))
    else $error("carry branch wrong");

  chk_unsigned_alias: assert property (
    s_take(OP_BRANCH_ON_UNSIGNED_GE) |=> res_o.pc_load == !$past(q.status[SB_C]))
    else $error("unsigned branch wrong");

  chk_sign_branch: assert property (
    s_take(OP_BRANCH_ON_POSITIVE) |=> res_o.pc_load == !$past(q.status[SB_N]))
    else $error("sign branch wrong");

  chk_signed_lt: assert property (
    s_take(OP_BRANCH_ON_SIGNED_LT) |=> res_o.pc_load ==
      ($past(q.status[SB_N]) ^ $past(q.status[SB_V])))
    else $error("signed branch wrong");

  chk_nibble_branch: assert property (
    s_take(OP_BRANCH_ON_NIBBLE_CARRY_LOW) |=> res_o.pc_load == !$past(q.status[SB_H]))
    else $error("nibble carry branch wrong");

  chk_spare_branch: assert property (
    s_take(OP_BRANCH_ON_SPARE_BIT_HIGH) |=> res_o.pc_load == $past(q.status[SB_T]))
    else $error("spare bit branch wrong");

  chk_wrap_branch: assert property (
    s_take(OP_BRANCH_ON_WRAP_LOW) |=> res_o.pc_load == !$past(q.status[SB_V]))
    else $error("wrap branch wrong");

  chk_wrap_set: assert property (
    s_take(OP_BRANCH_ON_WRAP_HIGH) |=> res_o.pc_load == $past(q.status[SB_V])
      && $stable(status_o))
    else $error("wrap set branch wrong");

  chk_irq_branch: assert property (
    s_take(OP_BRANCH_ON_IRQ_ON) |=> res_o.pc_load == $past(q.status[SB_I]))
    else $error("interrupt branch wrong");

  chk_long_skip: assert property (
    accept && is_skip && hit && req.next_two_word |=> res_o.pc_target ==
      $past(req.pc) + SKIP_LONG ##0 !req_ready [*2] ##1 req_ready)
    else $error("long skip wrong");

  chk_branch_target: assert property (
    accept && is_br && hit |=> res_o.pc_target == $past(req.pc)
      + {{(PC_W-7){$past(req.offset[6])}}, $past(req.offset)} + BR_BIAS)
    else $error("branch target wrong");

  // Redirect and flush travel together and always cost a refill cycle
  chk_flush_taken: assert property (
    res_o.pc_load || res_o.flush |-> res_o.pc_load && res_o.flush && res_o.done
      && !req_ready)
    else $error("flush missing on taken");

endmodule

// file: testbench/cbu_compare_skip_branch_test.sv
/*
  Self-checking bench for the compare, skip and branch unit.
  Assumes the unit answers one cycle after accepting a request and
  that its register port returns read data in the next cycle only.
*/
`timescale 1ns/100ps
module cbu_compare_skip_branch_test;
  import cbu_pkg::*;
  logic core_clk;
  logic rst_n;
  logic req_valid;
  cbu_req_t req;
  logic req_ready;
  cbu_res_t res_o;
  logic [7:0] status_o;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  int n_mismatch;
  int comparisons;
  logic [7:0] status_m;
  logic [7:0] n_taken;
  logic [PC_W-1:0] last_tgt;

  cbu_compare_skip_branch DUT (
    .core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .res_o(res_o), .status_o(status_o), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  // 25 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk_val(input logic [10:0] got, input logic [10:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("Compared %0d, mismatched %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Register port: one-cycle strobes, read data checked in the next cycle only
  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    if (a == REG_STATUS) status_m = d;
  endtask

  task automatic reg_read(input logic [1:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk_val(reg_rdata, exp);
    @(posedge core_clk);
    #1 chk_val(reg_rdata, 8'h00);
  endtask

  // Issue one request and judge the answer, the flags and the stall length
  task automatic exec(input cbu_req_t r, input logic take, input logic [PC_W-1:0] tgt,
                      input int stall);
    @(posedge core_clk);
    req <= r;
    req_valid <= 1'b1;
    @(posedge core_clk);
    req_valid <= 1'b0;
    #1 chk_val(res_o.done, 1'b1);
    chk_val(res_o.pc_load, take);
    chk_val(res_o.flush, take);
    chk_val(status_o, status_m);
    if (take) begin
      chk_val(res_o.pc_target, tgt);
      n_taken++;
      last_tgt = tgt;
    end
    for (int i = 0; i < stall; i++) begin
      chk_val(req_ready, 1'b0);
      @(posedge core_clk);
      #1;
    end
    chk_val(req_ready, 1'b1);
    // The answer pulses last one cycle, also when nothing stalls
    if (stall == 0) begin
      @(posedge core_clk);
      #1;
    end
    chk_val(res_o.done, 1'b0);
    chk_val(res_o.pc_load, 1'b0);
  endtask

  // Subtract flags: C Z N V H follow the difference, S and the rest kept
  task automatic compare(input cbu_op_t op, input logic [7:0] a, input logic [7:0] b);
    cbu_req_t r;
    logic cin;
    logic [8:0] d;
    logic [4:0] lo;
    int sd;
    cin = (op == OP_COMPARE_REGS_WITH_BORROW) ? status_m[SB_C] : 1'b0;
    d = {1'b0, a} - {1'b0, b} - {8'h00, cin};
    lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
    sd = int'($signed(a)) - int'($signed(b)) - int'(cin);
    // Borrow compare keeps zero only when the lower bytes were equal too
    status_m[SB_Z] = (d[7:0] == 8'h00)
                     && (op != OP_COMPARE_REGS_WITH_BORROW || status_m[SB_Z]);
    status_m[SB_C] = d[8];
    status_m[SB_N] = d[7];
    // Signed wrap and nibble borrow worked out from the operands directly
    status_m[SB_V] = (sd > 127) || (sd < -128);
    status_m[SB_H] = lo[4];
    r = '0;
    r.op = op;
    r.opa = a;
    r.opb = b;
    exec(r, 1'b0, '0, 0);
  endtask

  function automatic logic take_of(cbu_op_t op, logic [7:0] s, logic [2:0] b);
    case (op)
      OP_BRANCH_ON_STATUS_BIT_HIGH: return s[b];
      OP_BRANCH_ON_STATUS_BIT_LOW: return !s[b];
      OP_BRANCH_ON_EQUAL: return s[SB_Z];
      OP_BRANCH_ON_UNEQUAL: return !s[SB_Z];
      OP_BRANCH_ON_CARRY_HIGH, OP_BRANCH_ON_UNSIGNED_LT: return s[SB_C];
      OP_BRANCH_ON_CARRY_LOW, OP_BRANCH_ON_UNSIGNED_GE: return !s[SB_C];
      OP_BRANCH_ON_NEGATIVE: return s[SB_N];
      OP_BRANCH_ON_POSITIVE: return !s[SB_N];
      OP_BRANCH_ON_SIGNED_GE: return !(s[SB_N] ^ s[SB_V]);
      OP_BRANCH_ON_SIGNED_LT: return s[SB_N] ^ s[SB_V];
      OP_BRANCH_ON_NIBBLE_CARRY_HIGH: return s[SB_H];
      OP_BRANCH_ON_NIBBLE_CARRY_LOW: return !s[SB_H];
      OP_BRANCH_ON_SPARE_BIT_HIGH: return s[SB_T];
      OP_BRANCH_ON_SPARE_BIT_LOW: return !s[SB_T];
      OP_BRANCH_ON_WRAP_HIGH: return s[SB_V];
      OP_BRANCH_ON_WRAP_LOW: return !s[SB_V];
      OP_BRANCH_ON_IRQ_ON: return s[SB_I];
      default: return !s[SB_I];
    endcase
  endfunction

  // Every branch kind against four flag patterns, forward and backward offsets
  task automatic branch_table();
    cbu_req_t r;
    logic t;
    logic [7:0] pats [4] = '{8'h00, 8'hff, 8'h55, 8'haa};
    for (int p = 0; p < 4; p++) begin
      reg_write(REG_STATUS, pats[p]);
      for (int o = OP_BRANCH_ON_STATUS_BIT_HIGH; o <= OP_BRANCH_ON_IRQ_OFF; o++) begin
        r = '0;
        r.op = cbu_op_t'(o);
        r.bit_sel = 3'(o + p);
        r.offset = p[0] ? 7'h40 : 7'h3f;
        r.pc = 11'h100 + 11'(o);
        t = take_of(r.op, pats[p], r.bit_sel);
        exec(r, t, r.pc + {{4{r.offset[6]}}, r.offset} + BR_BIAS, t);
      end
    end
  endtask

  // Skips: equality, register bit and I/O bit, short and long
  task automatic skip_table();
    cbu_req_t r;
    logic t;
    for (int i = 0; i < 20; i++) begin
      r = '0;
      r.op = cbu_op_t'(OP_COMPARE_THEN_SKIP_ON_EQUAL + i % 5);
      r.opa = 8'h5a ^ 8'(i / 10);
      r.opb = 8'h5a;
      r.io_val = 8'h3c;
      r.bit_sel = 3'(i);
      r.pc = 11'h7fd;
      r.next_two_word = i[0];
      case (r.op)
        OP_COMPARE_THEN_SKIP_ON_EQUAL: t = (r.opa == r.opb);
        OP_SKIP_IF_REG_BIT_LOW: t = !r.opa[r.bit_sel];
        OP_SKIP_IF_REG_BIT_HIGH: t = r.opa[r.bit_sel];
        OP_SKIP_IF_IO_BIT_LOW: t = !r.io_val[r.bit_sel];
        default: t = r.io_val[r.bit_sel];
      endcase
      exec(r, t, r.pc + (i[0] ? SKIP_LONG : SKIP_SHORT), t ? 1 + i[0] : 0);
    end
  endtask

  // Reset in mid-run clears flags, the last target and the taken count
  task automatic reset_again();
    @(posedge core_clk);
    rst_n <= 1'b0;
    @(posedge core_clk);
    rst_n <= 1'b1;
    status_m = STATUS_RESET;
    n_taken = 8'h00;
    #1 chk_val(status_o, STATUS_RESET);
    chk_val(req_ready, 1'b1);
    chk_val(res_o.pc_target, '0);
    chk_val(res_o.done, 1'b0);
    reg_read(REG_TAKEN, 8'h00);
    reg_read(REG_TGT_LO, 8'h00);
  endtask

  // Main sequence
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    n_taken = 8'h00;
    status_m = STATUS_RESET;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    #1 chk_val(req_ready, 1'b1);
    chk_val(status_o, STATUS_RESET);
    reg_read(REG_STATUS, STATUS_RESET);
    reg_write(REG_STATUS, 8'h50);
    reg_read(REG_STATUS, 8'h50);
    compare(OP_COMPARE_REGS, 8'h10, 8'h10);
    compare(OP_COMPARE_REGS, 8'h80, 8'h01);
    compare(OP_COMPARE_IMMEDIATE, 8'h05, 8'h7f);
    compare(OP_COMPARE_REGS_WITH_BORROW, 8'h05, 8'h05);
    compare(OP_COMPARE_IMMEDIATE, 8'h20, 8'h20);
    compare(OP_COMPARE_REGS_WITH_BORROW, 8'h00, 8'hff);
    compare(OP_COMPARE_REGS_WITH_BORROW, 8'h01, 8'h00);
    skip_table();
    branch_table();
    reg_write(REG_TGT_LO, 8'hc3);
    reg_read(REG_TGT_LO, last_tgt[7:0]);
    reg_read(REG_TGT_HI, {5'h00, last_tgt[10:8]});
    reg_read(REG_TAKEN, n_taken);
    reset_again();
    compare(OP_COMPARE_REGS, 8'h01, 8'h02);
    conclude();
  end

  // Watchdog far beyond the expected run of about 375 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    conclude();
  end
endmodule
